// ==== src/event_counter.v ====
// How it works
// - count one event per rising edge of the count input pin
// - modes: free, fixed period, event target
// - target threshold adjustable; default action loads 100
// - period in whole seconds, adjustable, default 60
// - threshold writes only in target mode, period only in period mode
// - start/stop request toggles between idle and running
// - reported count and time refresh once per second while running
// - auto stop once elapsed time exceeds 43200 s
// - auto stop once event count exceeds four thousand million
// - event limit and threshold checked every 200 ms
// - optional trigger output high for the whole run
// - final count and time held after stop
// - period mode stops at period; target mode stops at threshold
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "event_counter_consts.vh"
module event_counter #(
	parameter integer SEC_CYCLES = `SEC_CYCLES,
	parameter integer CHECK_CYCLES = `CHECK_CYCLES
) (
	input wire mclk, // 200 MHz clock
	input wire rst_n, // async reset, active low
	input wire count_input_pin, // external event pulses
	input wire hsel, // ahb slave select
	input wire [31:0] haddr, // ahb address
	input wire [1:0] htrans, // ahb transfer type
	input wire hwrite, // ahb write
	input wire [2:0] hsize, // ahb size
	input wire [31:0] hwdata, // ahb write data
	input wire hready, // ahb bus ready
	output reg [31:0] hrdata, // ahb read data
	output reg hreadyout, // ahb slave ready
	output reg hresp, // ahb response, always okay
	output reg trigger_out // high while counting if enabled
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;

	reg [1:0] state;
	reg [1:0] mode;
	reg trig_en;
	reg [31:0] threshold;
	reg [31:0] period;
	reg [31:0] events;
	reg [31:0] seconds;
	reg [31:0] shown_events;
	reg [31:0] shown_seconds;
	reg pin_s1, pin_s2, pin_s3;
	reg wr_pend;
	reg [7:0] wr_addr;
	reg start_req;
	wire sec_tick;
	wire chk_tick;
	wire running = state == ST_RUN;
	wire rise = pin_s2 & ~pin_s3;

	// pin passes two flops; third stage only for edge detect
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
		end else begin
			pin_s1 <= count_input_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// dividers restart at start so the first second is a full second
	tick_divider #(.PERIOD(SEC_CYCLES)) u_sec (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(!running),
		.tick(sec_tick)
	);
	tick_divider #(.PERIOD(CHECK_CYCLES)) u_chk (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(!running),
		.tick(chk_tick)
	);

	// ahb write: capture address phase, apply in data phase
	wire addr_ok = hsel & hready & htrans[1];
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok & hwrite;
			if (addr_ok)
				wr_addr <= haddr[7:0];
		end
	end

	wire ctrl_wr = wr_pend && wr_addr == `ADDR_CTRL;
	wire in_target = mode == `MODE_TARGET;
	wire in_period = mode == `MODE_PERIOD;

	// stop conditions; limits use strict excess
	wire time_over = seconds > `TIME_LIMIT_S;
	wire event_over = chk_tick && events > `EVENT_LIMIT;
	wire target_hit = chk_tick && in_target &&
		events >= threshold;
	wire period_hit = in_period && seconds >= period;
	wire auto_stop = time_over | event_over | target_hit | period_hit;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			mode <= `MODE_FREE;
			trig_en <= 1'b0;
			threshold <= `THRESH_DEFAULT;
			period <= `PERIOD_DEFAULT_S;
			events <= 32'h00000000;
			seconds <= 32'h00000000;
			shown_events <= 32'h00000000;
			shown_seconds <= 32'h00000000;
			trigger_out <= 1'b0;
			start_req <= 1'b0;
		end else begin
			start_req <= ctrl_wr & hwdata[`CTRL_START];
			if (ctrl_wr) begin
				// mode change only while idle keeps a run consistent
				if (!running)
					mode <= hwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
				trig_en <= hwdata[`CTRL_TRIG_EN];
				if (hwdata[`CTRL_THR_DEF] && in_target)
					threshold <= `THRESH_DEFAULT;
				if (hwdata[`CTRL_PER_DEF] && in_period)
					period <= `PERIOD_DEFAULT_S;
			end
			if (wr_pend && wr_addr == `ADDR_THRESH && in_target)
				threshold <= hwdata;
			if (wr_pend && wr_addr == `ADDR_PERIOD && in_period)
				period <= hwdata;
			case (state)
			ST_IDLE: begin
				if (start_req) begin
					state <= ST_RUN;
					events <= 32'h00000000;
					seconds <= 32'h00000000;
					shown_events <= 32'h00000000;
					shown_seconds <= 32'h00000000;
					trigger_out <= trig_en;
				end
			end
			ST_RUN: begin
				if (rise && events != 32'hFFFFFFFF)
					events <= events + 32'h00000001;
				if (sec_tick) begin
					seconds <= seconds + 32'h00000001;
					shown_events <= events;
					shown_seconds <= seconds + 32'h00000001;
				end
				if (start_req || auto_stop) begin
					// final values are latched and held while idle
					state <= ST_IDLE;
					shown_events <= events;
					shown_seconds <= seconds;
					trigger_out <= 1'b0;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ahb read data is registered, zero wait states
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite) begin
				case (haddr[7:0])
				`ADDR_CTRL: hrdata <= {26'h0000000, 1'b0,
					1'b0, 1'b0, trig_en, mode};
				`ADDR_THRESH: hrdata <= threshold;
				`ADDR_PERIOD: hrdata <= period;
				`ADDR_STATUS: hrdata <= {30'h00000000, trigger_out,
					running};
				`ADDR_EVENTS: hrdata <= shown_events;
				`ADDR_SECONDS: hrdata <= shown_seconds;
				default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // event_counter

// ==== src/event_counter_consts.vh ====
`ifndef EVENT_COUNTER_CONSTS_VH
`define EVENT_COUNTER_CONSTS_VH
// clock rate and derived tick periods
`define CLK_HZ 200000000
`define CHECK_MS 200
`define CHECK_CYCLES ((`CLK_HZ / 1000) * `CHECK_MS)
`define SEC_CYCLES (`CLK_HZ)
// limits and defaults
`define TIME_LIMIT_S 32'd43200
`define EVENT_LIMIT 32'hEE6B2800
`define THRESH_DEFAULT 32'd100
`define PERIOD_DEFAULT_S 32'd60
// counting modes
`define MODE_FREE 2'h0
`define MODE_PERIOD 2'h1
`define MODE_TARGET 2'h2
// AHB register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_THRESH 8'h04
`define ADDR_PERIOD 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_EVENTS 8'h10
`define ADDR_SECONDS 8'h14
// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_TRIG_EN 2
`define CTRL_START 3
`define CTRL_THR_DEF 4
`define CTRL_PER_DEF 5
`endif

// ==== src/tick_divider.v ====
`timescale 1ns/1ps
// free-running divider that emits a one-cycle enable every period cycles
module tick_divider #(
	parameter integer PERIOD = 1000
) (
	input wire mclk, // system clock
	input wire rst_n, // async reset, active low
	input wire clear, // restart the count
	output reg tick // one-cycle enable
);
	reg [31:0] cnt;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (clear) begin
			cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (cnt == PERIOD - 1) begin
			cnt <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 32'h00000001;
			tick <= 1'b0;
		end
	end
endmodule // tick_divider

// ==== bench/event_counter_assertions.sv ====
`timescale 1ns/1ps
module event_counter_assertions (
	input wire mclk, // clock
	input wire rst_n, // reset
	input wire hsel, // select
	input wire [31:0] haddr, // address
	input wire [1:0] htrans, // transfer
	input wire hwrite, // write
	input wire [31:0] hwdata, // write data
	input wire hready, // ready
	input wire [31:0] hrdata, // read data
	input wire hreadyout, // ready out
	input wire hresp, // response
	input wire trigger_out // trigger
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence acc(w, a);
		hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == a;
	endsequence
	// start with trigger enabled is only issued from idle by the bench
	sequence go_trig;
		acc(1'b1, 8'h00) ##1 hwdata[3:2] == 2'h3 && !trigger_out;
	endsequence
	sequence halt;
		acc(1'b1, 8'h00) ##1 hwdata[3] && trigger_out;
	endsequence
	AST_READY: assert property (hreadyout)
		else $error("ready low");
	AST_OKAY: assert property (!hresp)
		else $error("response not okay");
	AST_START: assert property (go_trig |-> ##[1:3] trigger_out)
		else $error("trigger did not rise");
	AST_STOP: assert property (halt |-> ##[1:3] !trigger_out)
		else $error("trigger did not fall");
	AST_RISE: assert property ($rose(trigger_out) |-> $past(hwdata[3], 2))
		else $error("trigger rose without start");
	AST_CTRL_RD: assert property (acc(1'b0, 8'h00) |=> hrdata[5:3] == 3'h0)
		else $error("action bits read back");
	AST_STAT: assert property (acc(1'b0, 8'h0C) |=> hrdata[1] == $past(trigger_out))
		else $error("status trigger bit wrong");
	AST_RUN: assert property (acc(1'b0, 8'h0C) ##0 trigger_out |=> hrdata[0])
		else $error("running bit low");
endmodule // event_counter_assertions
bind event_counter event_counter_assertions u_event_counter_assertions(
	.mclk(mclk), .rst_n(rst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .trigger_out(trigger_out));

// ==== bench/pulse_src.sv ====
`timescale 1ns/1ps
module pulse_src (
	input wire mclk, // clock
	output logic pin // event pulses
);
	// idles low, as an input stage with pull-down would
	initial pin = 1'b0;
	task fire(input int n, input int w);
		repeat (n) begin
			repeat (w) @(posedge mclk);
			pin <= 1'b1;
			repeat (w) @(posedge mclk);
			pin <= 1'b0;
		end
	endtask
endmodule // pulse_src

// ==== bench/event_counter_bench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module event_counter_bench;
	logic mclk, rst_n, hsel, hwrite;
	logic [31:0] haddr, hwdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire [31:0] hrdata;
	wire hreadyout, hresp, trigger_out, pin;
	int err_count, n_checks;
	// short second and check tick keep the run small
	event_counter #(.SEC_CYCLES(50), .CHECK_CYCLES(10)) u_event_counter(
		.mclk(mclk), .rst_n(rst_n), .count_input_pin(pin), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .trigger_out(trigger_out));
	pulse_src u_pulse_src(.mclk(mclk), .pin(pin));
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		if (w) hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wait_low(input int n);
		// start lands two edges after the write, so let it take effect first
		repeat (2) @(posedge mclk);
		for (int i = 0; i < n && trigger_out !== 1'b0; i++) @(posedge mclk);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		err_count++;
		report_and_stop;
	end
	initial begin
		{rst_n, hsel, hwrite, haddr, hwdata, htrans} = 0;
		hsize = 3'h2;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		xf(0, 8'h04, 0); `CHK(q, 32'h64)
		xf(0, 8'h08, 0); `CHK(q, 32'h3C)
		xf(1, 8'h04, 5); xf(0, 8'h04, 0); `CHK(q, 32'h64)
		xf(1, 8'h18, 5); xf(0, 8'h18, 0); `CHK(q, 32'h0)
		xf(1, 8'h00, 2); xf(1, 8'h04, 7); xf(1, 8'h08, 9);
		xf(0, 8'h04, 0); `CHK(q, 32'h7)
		xf(0, 8'h08, 0); `CHK(q, 32'h3C)
		xf(1, 8'h00, 32'h12); xf(0, 8'h04, 0); `CHK(q, 32'h64)
		xf(1, 8'h00, 32'h0C); u_pulse_src.fire(10, 2);
		repeat (30) @(posedge mclk);
		xf(0, 8'h0C, 0); `CHK(trigger_out, 1'b1)
		xf(1, 8'h00, 32'h08); xf(0, 8'h10, 0); `CHK(q, 32'hA)
		`CHK(trigger_out, 1'b0)
		xf(0, 8'h14, 0); `CHK(q, 32'h1)
		repeat (60) @(posedge mclk);
		xf(0, 8'h10, 0); `CHK(q, 32'hA)
		xf(1, 8'h00, 8); xf(1, 8'h00, 8); xf(0, 8'h10, 0); `CHK(q, 32'h0)
		xf(1, 8'h00, 1); xf(1, 8'h08, 2); xf(1, 8'h00, 32'h0D);
		wait_low(150); `CHK(trigger_out, 1'b0)
		xf(0, 8'h14, 0); `CHK(q, 32'h2)
		xf(1, 8'h00, 2); xf(1, 8'h04, 3); xf(1, 8'h00, 32'h0E);
		u_pulse_src.fire(5, 2);
		wait_low(40); `CHK(trigger_out, 1'b0)
		xf(0, 8'h10, 0); `CHK(q >= 3, 1'b1)
		xf(0, 8'h14, 0); `CHK(q, 32'h0)
		report_and_stop;
	end
endmodule // event_counter_bench
